// ---- option_consts.svh ----
// Constants for the reset option loader
`ifndef OPTION_CONSTS_SVH
`define OPTION_CONSTS_SVH
`define OPT_RESET_ADDR 16'hFFFF
`define OPT_WDOG_ADDR 16'hFFDB
`define OPT_ERASED 8'hFF
`define OPT_B_AUTOSTART_N 0
`define OPT_B_GATE 2
`define OPT_B_PROTECT_N 3
`define OPT_B_VMON_OFF 6
`define OPT_B_CSP_INIT_N 7
`define OPT_UF_0 14'h03FF
`define OPT_UF_1 14'h0FFF
`define OPT_UF_2 14'h1FFF
`define OPT_UF_3 14'h3FFF
`define OPT_WIN_0 7'h19
`define OPT_WIN_1 7'h32
`define OPT_WIN_2 7'h4B
`define OPT_WIN_3 7'h64
`define REG_STATUS 4'h0
`define REG_RESET_OPT 4'h1
`define REG_WDOG_OPT 4'h2
`define REG_WDOG_COUNT_LO 4'h3
`define REG_WDOG_COUNT_HI 4'h4
`define REG_WINDOW 4'h5
`endif

// ---- option_pkg.sv ----
// Types for the reset option loader
package option_pkg;
  typedef struct packed {
    logic wd_autostart;
    logic rom_protected;
    logic vmon0_reset_armed;
    logic clk_src_protect;
    logic [13:0] wd_initial_count;
    logic [6:0] refresh_window_pct;
  } option_cfg_t;
  typedef enum logic [2:0] {FETCH_RESET, WAIT_RESET, FETCH_WDOG, WAIT_WDOG, DONE} load_state_t;
endpackage

// ---- option_byte_latch.sv ----
// One captured option byte, erased value until loaded
`timescale 1ns/1ns
`include "option_consts.svh"
module option_byte_latch
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Load side
  input wire logic load,
  input wire logic [7:0] data,
  // Held byte
  output logic [7:0] value_q
);
  logic [7:0] value_d;

  // Load whenever load is high; otherwise the byte holds
  always_comb
  begin
    value_d = value_q;
    if (load)
      value_d = data;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      value_q <= `OPT_ERASED;
    else
      value_q <= value_d;
  end
endmodule

// ---- option_byte_reset_config.sv ----
// Reset-time option byte fetch and decode
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`include "option_consts.svh"
// Notes on behaviour
// - Fetch both bytes from fixed flash addresses
// - Bit0 low starts watchdog after reset
// - Bit2 low disables ROM protection outright
// - Gated bit3 low enables ROM protection
// - Bit6 low arms voltage monitor reset
// - Bit7 low enables count source protection
// - Secondary bits1:0 choose watchdog underflow count
// - Secondary bits3:2 choose refresh window percent
// - Window percent relative to full count interval
// - Erased primary byte reads FFh defaults
// - Erased secondary byte reads FFh defaults
// - Protection refuses forced erase, uses ID check
module option_byte_reset_config
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Flash read port
  output logic flash_rd,
  output logic [15:0] flash_addr,
  input wire logic [7:0] flash_data,
  input wire logic flash_valid,
  // Forced erase request from serial programming
  input wire logic erase_req,
  output logic erase_grant,
  output logic id_check_req,
  // Decoded configuration
  output logic cfg_ready,
  output option_pkg::option_cfg_t cfg,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  // ****************************************
  // Fetch sequencer
  // ****************************************
  option_pkg::load_state_t state_q, state_d;
  logic load_reset, load_wdog;
  logic [7:0] reset_opt, wdog_opt;

  // Bytes come from flash, never from a writable register
  always_comb
  begin
    state_d = state_q;
    load_reset = 1'b0;
    load_wdog = 1'b0;
    unique case (state_q)
      option_pkg::FETCH_RESET: state_d = option_pkg::WAIT_RESET;
      option_pkg::WAIT_RESET:
        if (flash_valid)
        begin
          load_reset = 1'b1;
          state_d = option_pkg::FETCH_WDOG;
        end
      option_pkg::FETCH_WDOG: state_d = option_pkg::WAIT_WDOG;
      option_pkg::WAIT_WDOG:
        if (flash_valid)
        begin
          load_wdog = 1'b1;
          state_d = option_pkg::DONE;
        end
      option_pkg::DONE: state_d = option_pkg::DONE;
      // Unused encodings of the 3-bit state restart the fetch
      default: state_d = option_pkg::FETCH_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= option_pkg::FETCH_RESET;
    else
      state_q <= state_d;
  end

  // Request held through the wait so slow flash can answer late
  assign flash_rd = (state_q != option_pkg::DONE);
  assign flash_addr = (state_q == option_pkg::FETCH_RESET || state_q == option_pkg::WAIT_RESET)
    ? `OPT_RESET_ADDR : `OPT_WDOG_ADDR;
  assign cfg_ready = (state_q == option_pkg::DONE);

  // ****************************************
  // Byte holders
  // ****************************************
  // Erased value FFh until loaded, so blank parts get safe defaults
  option_byte_latch reset_latch
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(load_reset),
    .data(flash_data),
    .value_q(reset_opt)
  );
  option_byte_latch wdog_latch
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(load_wdog),
    .data(flash_data),
    .value_q(wdog_opt)
  );

  // ****************************************
  // Decode
  // ****************************************
  option_pkg::option_cfg_t dec;
  option_pkg::option_cfg_t cfg_q, cfg_d;
  logic cfg_ready_q;

  // Active-low option bits inverted into plain enables
  always_comb
  begin
    dec.wd_autostart = ~reset_opt[`OPT_B_AUTOSTART_N];
    dec.rom_protected = reset_opt[`OPT_B_GATE] & ~reset_opt[`OPT_B_PROTECT_N];
    dec.vmon0_reset_armed = ~reset_opt[`OPT_B_VMON_OFF];
    dec.clk_src_protect = ~reset_opt[`OPT_B_CSP_INIT_N];
    unique case (wdog_opt[1:0])
      2'h0: dec.wd_initial_count = `OPT_UF_0;
      2'h1: dec.wd_initial_count = `OPT_UF_1;
      2'h2: dec.wd_initial_count = `OPT_UF_2;
      2'h3: dec.wd_initial_count = `OPT_UF_3;
    endcase
    // Percent of the whole start-to-underflow interval
    unique case (wdog_opt[3:2])
      2'h0: dec.refresh_window_pct = `OPT_WIN_0;
      2'h1: dec.refresh_window_pct = `OPT_WIN_1;
      2'h2: dec.refresh_window_pct = `OPT_WIN_2;
      2'h3: dec.refresh_window_pct = `OPT_WIN_3;
    endcase
  end

  // Captured the cycle after both bytes are held, so no half-decoded value reaches the watchdog
  always_comb
  begin
    cfg_d = cfg_q;
    if (state_q == option_pkg::DONE && !cfg_ready_q)
      cfg_d = dec;
  end

  // Loaded flag trails cfg_ready by one cycle and marks cfg as final
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_q <= '{1'b0, 1'b0, 1'b0, 1'b0, `OPT_UF_3, `OPT_WIN_3};
      cfg_ready_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      cfg_ready_q <= cfg_ready;
    end
  end
  // Until loaded, cfg shows the blank-part defaults; consumers wait for the loaded flag
  assign cfg = cfg_q;

  // ****************************************
  // Forced erase gate
  // ****************************************
  // Protection turns erase requests into an ID check
  assign erase_grant = erase_req & cfg_ready_q & ~cfg_q.rom_protected;
  assign id_check_req = erase_req & cfg_ready_q & cfg_q.rom_protected;

  // ****************************************
  // Register port
  // ****************************************
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] scratch_q, scratch_d;

  // Option bytes read only here; writes go to status scratch bits only
  always_comb
  begin
    scratch_d = scratch_q;
    if (reg_wr && reg_addr == `REG_STATUS)
      scratch_d = {reg_wdata[7:1], 1'b0};
    rdata_d = 8'h00;
    if (reg_rd)
      unique case (reg_addr)
        `REG_STATUS: rdata_d = {scratch_q[7:1], cfg_ready_q};
        `REG_RESET_OPT: rdata_d = reset_opt;
        `REG_WDOG_OPT: rdata_d = wdog_opt;
        `REG_WDOG_COUNT_LO: rdata_d = cfg_q.wd_initial_count[7:0];
        `REG_WDOG_COUNT_HI: rdata_d = {2'h0, cfg_q.wd_initial_count[13:8]};
        `REG_WINDOW: rdata_d = {1'b0, cfg_q.refresh_window_pct};
        default: rdata_d = 8'h00;
      endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= 8'h00;
      scratch_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
      scratch_q <= scratch_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  // Held configuration, fixed fetch addresses and decode of the primary byte
  hold_after_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && $past(cfg_ready_q) |-> $stable(cfg_q)) else $error("config changed after load");
  addr_fixed_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    flash_rd |-> (flash_addr == `OPT_RESET_ADDR || flash_addr == `OPT_WDOG_ADDR)) else $error("bad option address");
  autostart_dec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q |-> cfg_q.wd_autostart == ~reset_opt[0]) else $error("autostart decode wrong");
  protect_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && !reset_opt[2] |-> !cfg_q.rom_protected) else $error("gate ignored");
  protect_bit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && reset_opt[2] |-> cfg_q.rom_protected == ~reset_opt[3]) else $error("protect decode wrong");
  vmon_dec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q |-> cfg_q.vmon0_reset_armed == ~reset_opt[6]) else $error("monitor decode wrong");
  csp_dec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q |-> cfg_q.clk_src_protect == ~reset_opt[7]) else $error("source protect decode wrong");

  // Every underflow and window code, not just the extremes
  count_dec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && wdog_opt[1:0] == 2'h3 |-> cfg_q.wd_initial_count == `OPT_UF_3) else $error("count decode wrong");
  count_code0_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && wdog_opt[1:0] == 2'h0 |-> cfg_q.wd_initial_count == `OPT_UF_0) else $error("count code 0 wrong");
  count_code1_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && wdog_opt[1:0] == 2'h1 |-> cfg_q.wd_initial_count == `OPT_UF_1) else $error("count code 1 wrong");
  count_code2_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && wdog_opt[1:0] == 2'h2 |-> cfg_q.wd_initial_count == `OPT_UF_2) else $error("count code 2 wrong");
  window_dec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && wdog_opt[3:2] == 2'h0 |-> cfg_q.refresh_window_pct == `OPT_WIN_0) else $error("window decode wrong");
  window_code1_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && wdog_opt[3:2] == 2'h1 |-> cfg_q.refresh_window_pct == `OPT_WIN_1) else $error("window code 1 wrong");
  window_code2_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && wdog_opt[3:2] == 2'h2 |-> cfg_q.refresh_window_pct == `OPT_WIN_2) else $error("window code 2 wrong");
  window_code3_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && wdog_opt[3:2] == 2'h3 |-> cfg_q.refresh_window_pct == `OPT_WIN_3) else $error("window code 3 wrong");

  // Blank parts must come up with every bit-equals-one meaning
  erased_primary_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && reset_opt == `OPT_ERASED |-> !cfg_q.wd_autostart && !cfg_q.rom_protected
      && !cfg_q.vmon0_reset_armed && !cfg_q.clk_src_protect) else $error("blank primary byte decode wrong");
  erased_wdog_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q && wdog_opt == `OPT_ERASED |-> cfg_q.wd_initial_count == `OPT_UF_3
      && cfg_q.refresh_window_pct == `OPT_WIN_3) else $error("blank watchdog byte decode wrong");

  // Erase gate is shut until the bytes are in, so an early request is never granted
  erase_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_q.rom_protected |-> !erase_grant) else $error("erase granted while protected");
  erase_open_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    erase_req && cfg_ready_q && !cfg_q.rom_protected |-> erase_grant && !id_check_req) else $error("erase not granted");
  id_check_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    erase_req && cfg_ready_q && cfg_q.rom_protected |-> id_check_req) else $error("id check not raised");
  gate_closed_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !cfg_ready_q |-> !erase_grant && !id_check_req) else $error("erase gate open before load");

  // Fetch walk as named steps: reset byte, watchdog address next, then loaded and held
  sequence reset_byte_taken_s;
    state_q == option_pkg::WAIT_RESET && flash_valid;
  endsequence
  sequence wdog_fetch_start_s;
    flash_rd && flash_addr == `OPT_WDOG_ADDR;
  endsequence
  sequence wdog_byte_taken_s;
    state_q == option_pkg::WAIT_WDOG && flash_valid;
  endsequence
  sequence load_finish_s;
    (cfg_ready && !cfg_ready_q) ##1 cfg_ready_q;
  endsequence
  fetch_first_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == option_pkg::FETCH_RESET |-> flash_rd && flash_addr == `OPT_RESET_ADDR) else $error("first fetch wrong");
  fetch_order_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reset_byte_taken_s |=> wdog_fetch_start_s) else $error("watchdog byte not fetched second");
  load_finish_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wdog_byte_taken_s |=> load_finish_s) else $error("load did not finish");
  bytes_held_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready_q |-> $stable(reset_opt) && $stable(wdog_opt)) else $error("option byte moved after load");
  fetch_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_ready |-> !flash_rd) else $error("fetch still active after load");

  // Register port: bytes read-only, data for one cycle only
  ro_bytes_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && !load_reset && !load_wdog |=> $stable(reset_opt) && $stable(wdog_opt)) else $error("byte written");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside answer cycle");
  status_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_addr == `REG_STATUS |=> reg_rdata[0] == $past(cfg_ready_q)) else $error("status bit wrong");
  unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_addr > `REG_WINDOW |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

// ---- option_byte_reset_config_tb.sv ----
// Self-checking bench for the reset option loader
`timescale 1ns/1ns
module option_byte_reset_config_tb;
  // ****************
  // Bench signals
  // ****************
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic flash_rd;
  logic [15:0] flash_addr;
  logic [7:0] flash_data = 8'h00;
  logic flash_valid = 1'b0;
  logic erase_req = 1'b0;
  logic erase_grant;
  logic id_check_req;
  logic cfg_ready;
  option_pkg::option_cfg_t cfg;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  int failures = 0;
  int cmp_count = 0;
  // Gate and protect bit pairs 00, 10, 11, 01; two cases arm the voltage monitor
  logic [7:0] rst_tab [4] = '{8'h71, 8'hB6, 8'h3F, 8'hCA};
  logic [13:0] uf_tab [4] = '{14'h03FF, 14'h0FFF, 14'h1FFF, 14'h3FFF};
  logic [6:0] win_tab [4] = '{7'h19, 7'h32, 7'h4B, 7'h64};

  // Free-running 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  option_byte_reset_config dut (.sys_clk(sys_clk), .nrst(nrst), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_data(flash_data), .flash_valid(flash_valid), .erase_req(erase_req), .erase_grant(erase_grant),
    .id_check_req(id_check_req), .cfg_ready(cfg_ready), .cfg(cfg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ****************
  // Tasks
  // ****************
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_val(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Answer one fetch; data inverted when not valid so stale bytes never pass
  task automatic serve(input logic [15:0] a, input logic [7:0] v);
    int n;
    n = 0;
    while (!(flash_rd === 1'b1 && flash_addr === a) && n < 50)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk_val("fetch address", 32'(a), 32'(flash_addr));
    @(posedge sys_clk);
    flash_valid <= 1'b1;
    flash_data <= v;
    @(posedge sys_clk);
    flash_valid <= 1'b0;
    flash_data <= ~v;
  endtask

  task automatic run_case(input logic [7:0] rb, input logic [7:0] wb);
    logic [7:0] d;
    logic [7:0] regs [6];
    logic prot;
    option_pkg::option_cfg_t saved;
    int n;
    prot = rb[2] & ~rb[3];
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk_val("reset address", 32'h0000FFFF, 32'(flash_addr));
    @(posedge sys_clk);
    nrst <= 1'b1;
    serve(16'hFFFF, rb);
    serve(16'hFFDB, wb);
    n = 0;
    while (cfg_ready !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    chk_bit("cfg ready", 1'b1, cfg_ready);
    chk_bit("autostart", ~rb[0], cfg.wd_autostart);
    chk_bit("rom protect", prot, cfg.rom_protected);
    chk_bit("vmon arm", ~rb[6], cfg.vmon0_reset_armed);
    chk_bit("src protect", ~rb[7], cfg.clk_src_protect);
    chk_val("count", 32'(uf_tab[wb[1:0]]), 32'(cfg.wd_initial_count));
    chk_val("window", 32'(win_tab[wb[3:2]]), 32'(cfg.refresh_window_pct));
    // Register view of the same selections
    regs = '{8'h01, rb, wb, uf_tab[wb[1:0]][7:0], {2'h0, uf_tab[wb[1:0]][13:8]}, {1'b0, win_tab[wb[3:2]]}};
    for (int i = 0; i < 6; i++)
    begin
      reg_read(4'(i), d);
      chk_val("register", 32'(regs[i]), 32'(d));
    end
    reg_write(4'h1, ~rb);
    reg_write(4'hF, 8'h5A);
    reg_read(4'h1, d);
    chk_val("ro byte", 32'(rb), 32'(d));
    reg_read(4'hF, d);
    chk_val("unmapped", 32'h0, 32'(d));
    reg_write(4'h0, 8'hA4);
    reg_read(4'h0, d);
    chk_val("scratch", 32'hA5, 32'(d));
    // Forced erase is refused only when protected
    @(posedge sys_clk);
    erase_req <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk_bit("erase grant", ~prot, erase_grant);
    chk_bit("id check", prot, id_check_req);
    // Later flash traffic must not move the held selections
    saved = '{~rb[0], prot, ~rb[6], ~rb[7], uf_tab[wb[1:0]], win_tab[wb[3:2]]};
    @(posedge sys_clk);
    erase_req <= 1'b0;
    flash_valid <= 1'b1;
    flash_data <= ~rb;
    repeat (3) @(posedge sys_clk);
    flash_valid <= 1'b0;
    #1;
    chk_val("held cfg", 32'(saved), 32'(cfg));
    chk_bit("fetch idle", 1'b0, flash_rd);
    $display("case %h %h done", rb, wb);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence: erased bytes first, then every code of both fields
  initial
  begin
    run_case(8'hFF, 8'hFF);
    for (int i = 0; i < 4; i++)
      run_case(rst_tab[i], {4'hF, 2'(3 - i), 2'(i)});
    summarize();
  end

  // Hang guard, far beyond the few hundred cycles the cases need
  initial
  begin
    #400000;
    failures++;
    $display("[FAIL] watchdog expected finish seen hang");
    summarize();
  end
endmodule
